// [rtl/apbss_decode.sv]
// Purpose: register-bus front end, 4 KB slot decoder and interrupt map
// Assumes: one write or one read at a time; word accesses only
// Notes:   absent slots answer at once with an error
//
// Overview of operation
// RULE1 - optional serial ports and watchdog by parameter
// RULE2 - byte order parameter, default little endian
// RULE3 - expansion ports off unless enabled
// RULE4 - gated interface clock matches peripheral clock
// RULE5 - gated clock held low when idle
// RULE6 - activity output alone controls clock gating
// RULE7 - 0x0000/0x1000/0x2000 go to timers
// RULE8 - 0x4000/0x5000/0x6000 go to serial ports
// RULE9 - 0x8000 watchdog, 0xB000 test slave
// RULE10 - 0xC000-0xF000 go to expansion ports 12-15
// RULE11 - slots 3, 7, 9, 10 never selected
// RULE12 - lines 0-5 serial rx/tx alternating
// RULE13 - lines 8-10 timers, line 11 unused
// RULE14 - lines 12-14 serial overflow
// RULE15 - lines 6, 7, 15, 16-31 never driven
// RULE16 - activity shows transfers in progress
// RULE17 - peripheral clock gated by clock enable
// RULE18 - ports 12-15 are plain APB3 slaves
// RULE19 - slot taken from address bits 15:12
// RULE20 - absent slot answers without waiting
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module apbss_decode
#(
   parameter int include_first_timer        = 1,
   parameter int include_second_timer       = 1,
   parameter int include_dual_timer         = 1,
   parameter int include_first_serial_port  = 1,
   parameter int include_second_serial_port = 1,
   parameter int include_third_serial_port  = 1,
   parameter int include_watchdog           = 1,
   parameter int include_test_slave         = 1,
   parameter int big_endian_select          = 0,
   parameter logic [3:0] expansion_slot_enable = 4'h0
)
(
   input  wire logic                          sys_clk,
   input  wire logic                          rstn,
   input  wire logic                          apb_clock_enable,
   input  wire logic [apbss_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [apbss_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [apbss_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [apbss_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output logic [apbss_pkg::NSLOT-1:0]        psel,
   output logic                               penable,
   output logic                               pwrite,
   output logic [apbss_pkg::OFS_W-1:0]        paddr,
   output logic [apbss_pkg::DATA_W-1:0]       pwdata,
   input  wire logic [apbss_pkg::NSLOT-1:0]   pready,
   input  wire logic [apbss_pkg::NSLOT-1:0]   pslverr,
   input  wire logic [apbss_pkg::NSLOT*apbss_pkg::DATA_W-1:0] prdata,
   output logic                               bus_activity_out,
   input  wire logic [2:0]                    uart_rx_irq,
   input  wire logic [2:0]                    uart_tx_irq,
   input  wire logic [2:0]                    uart_ovf_irq,
   input  wire logic [2:0]                    timer_irq,
   output logic [apbss_pkg::IRQ_W-1:0]        irq_vector
);
   import apbss_pkg::*;

   // slots with a peripheral behind them; 3, 7, 9, 10 stay dark
   localparam logic [NSLOT-1:0] SLOT_EN = {           // RULE11
      expansion_slot_enable,                          // RULE3
      include_test_slave[0], 1'b0, 1'b0,              // RULE9
      include_watchdog[0], 1'b0,                      // RULE1
      include_third_serial_port[0],
      include_second_serial_port[0],
      include_first_serial_port[0], 1'b0,             // RULE8
      include_dual_timer[0], include_second_timer[0],
      include_first_timer[0]};                        // RULE7

   // refuse values above 1, and below 0 for include_first_timer and big_endian_select
   if (include_first_timer > 1 || include_second_timer > 1 ||
       include_dual_timer > 1 || include_first_serial_port > 1 ||
       include_second_serial_port > 1 || include_third_serial_port > 1 ||
       include_watchdog > 1 || include_test_slave > 1 ||
       big_endian_select > 1 || include_first_timer < 0 ||
       big_endian_select < 0)
   begin : g_bad_param
      $error("inclusion and byte-order parameters must be 0 or 1");
   end

   // byte swap used only in the big-endian build
   function automatic logic [DATA_W-1:0] order_bytes(input logic [DATA_W-1:0] w);
      if (big_endian_select == 1)                     // RULE2
         order_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
      else
         order_bytes = w;
   endfunction

   apbss_state_t      state_q;                 // transfer sequencer
   logic              aw_have_q;               // write address held
   logic              w_have_q;                // write data held
   logic [ADDR_W-1:0] waddr_q;                 // held write address
   logic [DATA_W-1:0] wdata_q;                 // held write data
   logic [ADDR_W-1:0] addr_q;                  // address of the live transfer
   logic              awready_q;
   logic              wready_q;
   logic              arready_q;
   logic              bvalid_q;
   logic              rvalid_q;
   logic [1:0]        bresp_q;
   logic [1:0]        rresp_q;
   logic [DATA_W-1:0] rdata_q;
   logic [NSLOT-1:0]  psel_q;                  // one-hot slot select
   logic [NSLOT-1:0]  psel_d;
   logic              penable_q;
   logic              pwrite_q;
   logic [DATA_W-1:0] pwdata_q;
   logic              active_q;                // transfer on the peripheral bus
   logic [SLOT_W-1:0] slot;                    // slot of the live transfer
   logic              aw_hs;
   logic              w_hs;
   logic              ar_hs;
   logic              wr_go;                   // both halves of a write present

   assign slot  = addr_q[ADDR_W-1:OFS_W];      // RULE19
   assign aw_hs = s_axi_awvalid & awready_q;
   assign w_hs  = s_axi_wvalid & wready_q;
   assign ar_hs = s_axi_arvalid & arready_q;
   assign wr_go = (aw_have_q | aw_hs) & (w_have_q | w_hs);

   // one select bit per slot, only where a peripheral exists
   for (genvar i = 0; i < NSLOT; i++)
   begin : g_sel
      assign psel_d[i] = (slot == SLOT_W'(i)) & SLOT_EN[i];  // RULE10
   end

   // write halves are taken in either order and held until answered
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         waddr_q   <= '0;
         wdata_q   <= RST_WORD;
      end
      else if (apb_clock_enable)
      begin
         if (aw_hs)
         begin
            aw_have_q <= 1'b1;
            waddr_q   <= s_axi_awaddr;
         end
         if (w_hs)
         begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
         end
         // a finished write frees both halves
         if (state_q == ST_WRESP && s_axi_bready)
         begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end
      end
   end

   // readiness: reads only when no write half is pending
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
      end
      else if (apb_clock_enable)
      begin
         if (state_q == ST_IDLE && !ar_hs && !wr_go)
         begin
            // a taken half drops its ready; the other stays open
            awready_q <= !aw_have_q && !aw_hs;
            wready_q  <= !w_have_q && !w_hs;
            arready_q <= !aw_have_q && !w_have_q && !aw_hs && !w_hs;
         end
         else
         begin
            // busy: nothing new until the answer is taken
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
         end
      end
   end

   // sequencer: decode, setup, access, answer
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         state_q  <= ST_IDLE;
         addr_q   <= '0;
         pwrite_q <= 1'b0;
      end
      else if (apb_clock_enable)
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               // a read taken this edge goes first; the write waits
               if (ar_hs)
               begin
                  addr_q   <= s_axi_araddr;
                  pwrite_q <= 1'b0;
                  state_q  <= ST_DECODE;
               end
               else if (wr_go)
               begin
                  addr_q   <= aw_hs ? s_axi_awaddr : waddr_q;
                  pwrite_q <= 1'b1;
                  state_q  <= ST_DECODE;
               end
            end
            ST_DECODE:
            begin
               // dark slot: answer right away instead of waiting
               if (!SLOT_EN[slot])                           // RULE20
                  state_q <= pwrite_q ? ST_WRESP : ST_RRESP;
               else
                  state_q <= ST_SETUP;
            end
            ST_SETUP:
               state_q <= ST_ACCESS;                         // RULE18
            ST_ACCESS:
            begin
               // the peripheral sets the wait; no timeout here
               if (pready[slot])
                  state_q <= pwrite_q ? ST_WRESP : ST_RRESP;
            end
            ST_WRESP:
            begin
               if (s_axi_bready)
                  state_q <= ST_IDLE;
            end
            ST_RRESP:
            begin
               if (s_axi_rready)
                  state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // peripheral-side select, enable and write data
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         psel_q    <= '0;
         penable_q <= 1'b0;
         pwdata_q  <= RST_WORD;
      end
      else if (apb_clock_enable)
      begin
         if (state_q == ST_DECODE && SLOT_EN[slot])
         begin
            psel_q   <= psel_d;                              // RULE7
            pwdata_q <= order_bytes(wdata_q);                // RULE2
         end
         else if (state_q == ST_SETUP)
            penable_q <= 1'b1;                               // RULE18
         else if (state_q == ST_ACCESS && pready[slot])
         begin
            psel_q    <= '0;
            penable_q <= 1'b0;
         end
      end
   end

   // activity follows the select so idle time can stop the gated clock
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         active_q <= 1'b0;
      else if (apb_clock_enable)
      begin
         if (state_q == ST_DECODE && SLOT_EN[slot])
            active_q <= 1'b1;                                // RULE16
         else if (state_q == ST_ACCESS && pready[slot])
            active_q <= 1'b0;                                // RULE6
      end
   end

   // answers: dark slots give an error, live ones pass the slave's
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= RST_WORD;
      end
      else if (apb_clock_enable)
      begin
         if (state_q == ST_DECODE && !SLOT_EN[slot])
         begin
            bvalid_q <= pwrite_q;                            // RULE20
            rvalid_q <= !pwrite_q;
            bresp_q  <= RESP_SLVERR;
            rresp_q  <= RESP_SLVERR;
            rdata_q  <= RST_WORD;
         end
         else if (state_q == ST_ACCESS && pready[slot])
         begin
            bvalid_q <= pwrite_q;
            rvalid_q <= !pwrite_q;
            bresp_q  <= pslverr[slot] ? RESP_SLVERR : RESP_OKAY;
            rresp_q  <= pslverr[slot] ? RESP_SLVERR : RESP_OKAY;
            rdata_q  <= order_bytes(prdata[slot*DATA_W +: DATA_W]);  // RULE2
         end
         else
         begin
            if (s_axi_bready)
               bvalid_q <= 1'b0;
            if (s_axi_rready)
               rvalid_q <= 1'b0;
         end
      end
   end

   // interrupt mapping in its own module
   apbss_irq_if irq_ifc ();
   assign irq_ifc.rx  = uart_rx_irq;
   assign irq_ifc.tx  = uart_tx_irq;
   assign irq_ifc.ovf = uart_ovf_irq;
   assign irq_ifc.tmr = timer_irq;

   apbss_irq_map #(
      .UART_PRESENT ({include_third_serial_port[0],
                      include_second_serial_port[0],
                      include_first_serial_port[0]}),      // RULE1
      .TMR_PRESENT  ({include_dual_timer[0], include_second_timer[0],
                      include_first_timer[0]})
   ) u_irq_map (
      .sys_clk          (sys_clk),
      .rstn             (rstn),
      .apb_clock_enable (apb_clock_enable),
      .ifc              (irq_ifc.map)
   );

   // every output straight from a flop
   assign s_axi_awready    = awready_q;
   assign s_axi_wready     = wready_q;
   assign s_axi_arready    = arready_q;
   assign s_axi_bvalid     = bvalid_q;
   assign s_axi_bresp      = bresp_q;
   assign s_axi_rvalid     = rvalid_q;
   assign s_axi_rresp      = rresp_q;
   assign s_axi_rdata      = rdata_q;
   assign psel             = psel_q;
   assign penable          = penable_q;
   assign pwrite           = pwrite_q;
   assign paddr            = addr_q[OFS_W-1:0];
   assign pwdata           = pwdata_q;
   assign bus_activity_out = active_q;
   assign irq_vector       = irq_ifc.vec;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn || !apb_clock_enable);

   chk_sel_one_hot: assert property ($onehot0(psel_q)) // RULE19
      else $error("more than one slot selected");
   chk_dark_slot_idle: assert property ((psel_q & ~SLOT_EN) == '0) // RULE11
      else $error("dark slot selected");
   chk_timer_slot_route: assert property ( // RULE7
      psel_q[SLOT_TIMER1] |-> addr_q[15:12] == SLOT_TIMER1)
      else $error("second timer selected for wrong address");
   chk_serial_slot_route: assert property ( // RULE8
      psel_q[SLOT_UART0 + 2] |-> addr_q[15:12] == 4'h6)
      else $error("third serial port selected for wrong address");
   chk_test_slot_route: assert property ( // RULE9
      psel_q[SLOT_TEST] |-> addr_q[15:12] == SLOT_TEST)
      else $error("test slave selected for wrong address");
   chk_exp_slot_route: assert property ( // RULE10
      (|psel_q[15:12]) |-> psel_q[slot] && slot >= SLOT_EXP0)
      else $error("expansion select does not match address");
   chk_setup_then_access: assert property ( // RULE18
      $rose(|psel_q) |-> !penable_q ##1 penable_q && $stable(psel_q))
      else $error("access phase did not follow setup");
   chk_activity_with_sel: assert property ( // RULE6
      bus_activity_out == (|psel_q))
      else $error("activity output disagrees with select");
   chk_dark_answer_fast: assert property ( // RULE20
      state_q == ST_DECODE && !SLOT_EN[slot]
      |=> (bvalid_q || rvalid_q) && psel_q == '0)
      else $error("dark slot not answered next cycle");
   chk_write_byte_order: assert property ( // RULE2
      state_q == ST_SETUP && pwrite_q |-> pwdata_q == order_bytes(wdata_q))
      else $error("write data byte order wrong");

   cov_live_write: cover property (state_q == ST_ACCESS && pwrite_q && pready[slot]);
   cov_live_read: cover property (state_q == ST_ACCESS && !pwrite_q && pready[slot]);
   cov_dark_access: cover property (state_q == ST_DECODE && !SLOT_EN[slot]);
   cov_wait_state: cover property (state_q == ST_ACCESS ##1 state_q == ST_ACCESS);
endmodule
`default_nettype wire

// [rtl/apbss_irq_if.sv]
// Purpose: carries peripheral interrupt sources to the line mapper
// Assumes: all signals on sys_clk
// Notes:   vec is registered inside the mapper
`timescale 1ns/1ps
`default_nettype none
interface apbss_irq_if;
   logic [2:0]  rx;                          // serial receive requests
   logic [2:0]  tx;                          // serial transmit requests
   logic [2:0]  ovf;                         // serial overflow requests
   logic [2:0]  tmr;                         // timer requests
   logic [31:0] vec;                         // mapped request vector
   modport src (output rx, tx, ovf, tmr, input vec);
   modport map (input rx, tx, ovf, tmr, output vec);
endinterface
`default_nettype wire

// [rtl/apbss_irq_map.sv]
// Purpose: places peripheral interrupts onto the 32-line request vector
// Assumes: sources are synchronous to sys_clk
// Notes:   absent peripherals contribute nothing
`timescale 1ns/1ps
`default_nettype none
module apbss_irq_map
#(
   parameter logic [2:0] UART_PRESENT = 3'h7,   // one bit per serial port
   parameter logic [2:0] TMR_PRESENT  = 3'h7    // timer, timer, dual timer
)
(
   input wire logic  sys_clk,
   input wire logic  rstn,
   input wire logic  apb_clock_enable,
   apbss_irq_if.map  ifc
);
   import apbss_pkg::*;

   logic [IRQ_W-1:0] vec_d;                  // next vector, all else zero

   // per-port placement; unlisted lines stay zero
   always_comb
   begin
      vec_d = RST_IRQ;                                                 // RULE15
      for (int n = 0; n < NUART; n++)
      begin
         vec_d[IRQ_UART_RX0 + 2*n]     = ifc.rx[n] & UART_PRESENT[n];  // RULE12
         vec_d[IRQ_UART_RX0 + 2*n + 1] = ifc.tx[n] & UART_PRESENT[n];  // RULE12
         vec_d[IRQ_UART_OVF0 + n]      = ifc.ovf[n] & UART_PRESENT[n]; // RULE14
      end
      for (int t = 0; t < NTMR; t++)
      begin
         vec_d[IRQ_TIMER0 + t] = ifc.tmr[t] & TMR_PRESENT[t];          // RULE13
      end
   end

   // one register stage so the vector leaves from a flop
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         ifc.vec <= RST_IRQ;
      else if (apb_clock_enable)
         ifc.vec <= vec_d;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn || !apb_clock_enable);

   chk_reserved_lines_low: assert property ( // RULE15
      ifc.vec[7:6] == 2'h0 && ifc.vec[11] == 1'b0 && ifc.vec[31:15] == 17'h0)
      else $error("reserved interrupt line driven");
   chk_uart_rx_tx_map: assert property ( // RULE12
      rstn && apb_clock_enable
      |=> ifc.vec[5:0] == ($past({ifc.tx[2], ifc.rx[2], ifc.tx[1], ifc.rx[1],
                                  ifc.tx[0], ifc.rx[0]})
                           & {{2{UART_PRESENT[2]}}, {2{UART_PRESENT[1]}},
                              {2{UART_PRESENT[0]}}}))
      else $error("serial rx/tx lines misplaced");
   chk_timer_line_map: assert property ( // RULE13
      rstn && apb_clock_enable && ifc.tmr[1] && TMR_PRESENT[1] |=> ifc.vec[9])
      else $error("second timer line not on 9");
   chk_overflow_map: assert property ( // RULE14
      rstn && apb_clock_enable |=> ifc.vec[14:12] == ($past(ifc.ovf) & UART_PRESENT))
      else $error("overflow lines misplaced");
endmodule
`default_nettype wire

// [rtl/apbss_pkg.sv]
// Purpose: shared constants for the peripheral subsystem decoder
// Assumes: 64 KB window split into sixteen 4 KB slots
// Notes:   slot codes, bus answer codes and interrupt line positions
package apbss_pkg;
   localparam int ADDR_W = 16;               // subsystem window address width
   localparam int OFS_W  = 12;               // offset inside one 4 KB slot
   localparam int SLOT_W = 4;                // slot number width
   localparam int DATA_W = 32;               // data word width
   localparam int NSLOT  = 16;               // number of slots
   localparam int IRQ_W  = 32;               // interrupt request vector width
   localparam int NUART  = 3;                // serial ports
   localparam int NTMR   = 3;                // timer, timer, dual timer
   // slot numbers (address bits 15:12)
   localparam logic [3:0] SLOT_TIMER0 = 4'h0;
   localparam logic [3:0] SLOT_TIMER1 = 4'h1;
   localparam logic [3:0] SLOT_DTIMER = 4'h2;
   localparam logic [3:0] SLOT_UART0  = 4'h4;
   localparam logic [3:0] SLOT_WDOG   = 4'h8;
   localparam logic [3:0] SLOT_TEST   = 4'hB;
   localparam logic [3:0] SLOT_EXP0   = 4'hC;
   // write/read answer codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // interrupt line positions
   localparam int IRQ_UART_RX0  = 0;         // rx at 2n, tx at 2n+1
   localparam int IRQ_TIMER0    = 8;
   localparam int IRQ_UART_OVF0 = 12;
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] RST_IRQ  = 32'h0000_0000;
   // transfer sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_SETUP, ST_ACCESS,
                             ST_WRESP, ST_RRESP} apbss_state_t;
endpackage

// [sim/apbss_slave_model.sv]
// Purpose: far-side peripheral slaves for the slot decoder
// Assumes: one slot selected at a time
// Notes:   offset bit 2 adds two waits, offsets 0xFxx answer error
`timescale 1ns/1ps
`default_nettype none
module apbss_slave_model
(
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         act,
   input  wire logic [15:0]  psel,
   input  wire logic         penable,
   input  wire logic [11:0]  paddr,
   output logic [15:0]       pready,
   output logic [15:0]       pslverr,
   output logic [511:0]      prdata
);
   logic [1:0] wait_q;  // wait states still owed
   logic       gate_q;  // gate taken on the low phase
   logic       gclk;    // gated clock, held low when idle
   // low-phase capture keeps gclk free of glitches
   always @(negedge sys_clk)
      gate_q <= act;
   assign gclk = sys_clk & gate_q;
   // load in setup, count down in access
   always_ff @(posedge gclk)
   begin
      if (!rstn || !penable)
         wait_q <= {paddr[2], 1'b0};
      else if (wait_q != 2'h0)
         wait_q <= wait_q - 2'h1;
   end
   for (genvar n = 0; n < 16; n++)
   begin : g_slot
      logic [31:0] rd;  // word this slot returns
      assign rd = {4'hA, 4'(n), 12'h000, paddr};
      assign pready[n] = psel[n] & penable & (wait_q == 2'h0);
      assign pslverr[n] = pready[n] & (paddr[11:8] == 4'hF);
      // a released bus shows the inverse, never a stale word
      assign prdata[32*n +: 32] = psel[n] ? rd : ~rd;
   end
endmodule
`default_nettype wire

// [sim/tb_apbss_decode.sv]
// Purpose: self-checking bench for the slot decoder
// Assumes: default build, expansion slots 12 and 14 enabled
// Notes:   slots walked as table rows, then error, irq and reset cases
`timescale 1ns/1ps
`default_nettype none
module tb_apbss_decode;
   import apbss_pkg::*;
   localparam logic [15:0] LIVE = 16'h5977;  // rows: slots that answer
   localparam logic [15:0] LB = 16'h0857;    // rows of the big-endian build
   logic         sys_clk, rstn, awv, wv, bre, arv, rre, awr, wr, arr, rvb;
   logic         bvalid, rvalid, penable, pwrite, act;
   logic [1:0]   bresp, rresp, r;
   logic [15:0]  aw, ar, psel, pready, pslverr, sn, pselb;
   logic [11:0]  paddr, irq_src;
   logic [31:0]  wd, rdata, pwdata, irq, got, e, eb, gb, rdb, pwb, irqb;
   logic [511:0] prdata;
   int           miscompares, num_checks, cyc, b;
   apbss_decode #(.expansion_slot_enable(4'h5)) dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .apb_clock_enable(1'b1),
      .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bre),
      .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rre), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .bus_activity_out(act), .uart_rx_irq(irq_src[2:0]),
      .uart_tx_irq(irq_src[5:3]), .uart_ovf_irq(irq_src[8:6]),
      .timer_irq(irq_src[11:9]), .irq_vector(irq));
   // big-endian build, no second serial port, no watchdog
   apbss_decode #(.include_second_serial_port(0), .include_watchdog(0),
      .big_endian_select(1)) dut_be (
      .sys_clk(sys_clk), .rstn(rstn), .apb_clock_enable(1'b1), .s_axi_awaddr(aw),
      .s_axi_awvalid(awv), .s_axi_awready(), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
      .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(),
      .s_axi_rdata(rdb), .s_axi_rresp(), .s_axi_rvalid(rvb), .s_axi_rready(rre),
      .psel(pselb), .penable(), .pwrite(), .paddr(), .pwdata(pwb), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .bus_activity_out(),
      .uart_rx_irq(irq_src[2:0]), .uart_tx_irq(irq_src[5:3]),
      .uart_ovf_irq(irq_src[8:6]), .timer_irq(irq_src[11:9]), .irq_vector(irqb));
   apbss_slave_model slv_u (.sys_clk(sys_clk), .rstn(rstn), .act(act), .psel(psel),
      .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
      .prdata(prdata));
   // verdict and end of run
   task automatic stop_test;
      if (miscompares == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // compare one value
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", nm, x, g);
      end
   endtask
   // one bus transfer; sn gathers every slot select seen meanwhile
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
      sn = 16'h0;
      got = 32'h0;
      gb = 32'h0;
      @(posedge sys_clk);
      aw <= a;
      ar <= a;
      wd <= d;
      awv <= w;
      wv <= w;
      bre <= w;
      arv <= !w;
      rre <= !w;
      do
      begin
         @(posedge sys_clk);
         sn = sn | psel;
         if (w & |psel)
            got = pwdata;
         if (w & |pselb)
            gb = pwb;
         if (rvb)
            gb = rdb;
         if (|psel)
            chk("pwrite", 32'(w), 32'(pwrite));
         awv <= awv & ~awr;
         wv <= wv & ~wr;
         arv <= arv & ~arr;
      end
      while ((w ? bvalid : rvalid) !== 1'b1);
      r = w ? bresp : rresp;
      if (!w)
         got = rdata;
      bre <= 1'b0;
      rre <= 1'b0;
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // activity watch and hang limit
   always @(posedge sys_clk)
   begin
      cyc++;
      if (rstn & (act | |psel))
         chk("activity", 32'(|psel), 32'(act));
      if (cyc == 6000)
      begin
         miscompares++;
         stop_test();
      end
   end
   initial
   begin
      {rstn, awv, wv, bre, arv, rre, aw, ar, wd} = '0;
      irq_src = 12'hFFF;  // sources busy while in reset
      repeat (4) @(posedge sys_clk);
      chk("reset irq", RST_IRQ, irq);
      chk("reset ready", 32'h0, 32'({awr, wr, arr, bvalid, rvalid}));
      rstn <= 1'b1;
      // row loop: one read and one write per slot, with waits
      for (int s = 0; s < 16; s++)
      begin
         e = LIVE[s] ? {4'hA, 4'(s), 12'h000, 12'h004} : 32'h0;
         eb = {<<8{e}};
         xfer(1'b0, {4'(s), 12'h004}, 32'h0);
         chk("read resp", LIVE[s] ? RESP_OKAY : RESP_SLVERR, r);
         chk("read data", e, got);
         chk("be read", LB[s] ? eb : 32'h0, gb);
         chk("select", LIVE[s] ? 32'(1) << s : 32'h0, sn);
         xfer(1'b1, {4'(s), 12'h004}, ~e);
         chk("write resp", LIVE[s] ? RESP_OKAY : RESP_SLVERR, r);
         chk("write data", LIVE[s] ? ~e : 32'h0, got);
         chk("be write", LB[s] ? ~eb : 32'h0, gb);
      end
      xfer(1'b0, 16'hBF00, 32'h0);
      chk("slave error", RESP_SLVERR, r);
      // interrupt sources one at a time
      for (int k = 0; k < 12; k++)
      begin
         irq_src <= 12'(1 << k);
         b = k < 3 ? 2 * k : k < 6 ? 2 * k - 5 : k < 9 ? k + 6 : k - 1;
         repeat (2) @(posedge sys_clk);
         chk("irq line", 32'(1) << b, irq);
      end
      irq_src <= 12'hFFF;
      repeat (2) @(posedge sys_clk);
      chk("irq all", 32'h0000_773F, irq);
      chk("irq be", 32'h0000_5733, irqb);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("mid reset irq", RST_IRQ, irq);
      stop_test();
   end
endmodule
`default_nettype wire
